// File: uepr_checker.sv
// Port checker for the endpoint packet-ready block
`timescale 1ns/1ps
module uepr_checker
    import uepr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic pready,
    // Link and status
    input wire logic ctrl_read_data_stage,
    input wire logic [NUM_EP-1:0] ep_tx_ack,
    input wire logic [NUM_EP-1:1] ep_rx_done,
    input wire logic [NUM_EP-1:0] ep_tx_armed,
    input wire logic irq
);
    logic [DATA_W-1:0] en_r;
    logic [DATA_W-1:0] dir_r;
    wire wr_done = psel && penable && pready && pwrite;
    wire wr_ctrl = wr_done && (paddr == OFF_CTRL_EP_STATUS);
    wire wr_ep1 = wr_done && (paddr == OFF_EP_STATUS_BASE);
    wire wr_dir = wr_done && (paddr == OFF_EP_DIRECTION);
    wire wr_en = wr_done && (paddr == OFF_INT_ENABLE_FIRST);
    // Shadows so masking can be judged from the ports
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            en_r <= WORD_ZERO;
            dir_r <= WORD_ZERO;
        end else begin
            en_r <= wr_en ? pwdata : en_r;
            dir_r <= wr_dir ? pwdata : dir_r;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence s_access_start;
        psel && penable && !pready;
    endsequence
    sequence s_arm_ctrl;
        wr_ctrl && pwdata[TX_RDY_BIT];
    endsequence
    a_apb_one_wait: assert property (s_access_start |=> pready ##1 !pready)
        else $error("pready not a single pulse after one wait");
    a_ctrl_arm: assert property (s_arm_ctrl |=> ep_tx_armed[0])
        else $error("control arm write did not set ready");
    a_ctrl_clear: assert property (
        ctrl_read_data_stage && !(wr_ctrl && pwdata[TX_RDY_BIT]) |=> !ep_tx_armed[0])
        else $error("data stage did not clear control ready");
    a_zero_ignored: assert property (
        wr_ctrl && !pwdata[TX_RDY_BIT] && !ctrl_read_data_stage && !ep_tx_ack[0]
        |=> $stable(ep_tx_armed[0]))
        else $error("zero write changed control ready");
    a_ack_clear: assert property (
        ep_tx_ack[1] && ep_tx_armed[1] && !(wr_ep1 && pwdata[TX_RDY_BIT]) |=> !ep_tx_armed[1])
        else $error("ack did not clear transmit ready");
    a_no_ack_hold: assert property (
        ep_tx_armed[1] && !ep_tx_ack[1] && !wr_dir && !$past(wr_dir) |=> ep_tx_armed[1])
        else $error("transmit ready dropped without ack");
    a_irq_masked: assert property (
        en_r == WORD_ZERO && $past(en_r) == WORD_ZERO && $past(en_r, 2) == WORD_ZERO |-> !irq)
        else $error("interrupt raised with all enables off");
    a_rx_irq: assert property (
        ep_rx_done[1] && en_r[EN_RX_LSB+1] && !dir_r[1] |-> ##2 irq)
        else $error("receive done gave no enabled interrupt");
    a_tx_irq: assert property (
        $fell(ep_tx_armed[1]) && en_r[EN_TX_LSB+1] && dir_r[1] |=> irq)
        else $error("transmit free gave no enabled interrupt");
endmodule : uepr_checker

bind uepr_top uepr_checker uepr_checker_i (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .ctrl_read_data_stage(ctrl_read_data_stage),
    .ep_tx_ack(ep_tx_ack),
    .ep_rx_done(ep_rx_done),
    .ep_tx_armed(ep_tx_armed),
    .irq(irq)
);

// File: uepr_ep_cell.sv
// Packet-ready package and the per-endpoint ready/interrupt cell
`timescale 1ns/1ps

package uepr_pkg;
    localparam int NUM_EP = 6;
    localparam int CNT_W = 7;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int EP_SEL_W = 3;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL_EP_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_INT_ENABLE_FIRST = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_INT_PENDING = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_EP_DIRECTION = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_EP_STATUS_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RX_COUNT_BASE = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_TX_FIFO_BASE = 8'h50;
    localparam logic [ADDR_W-1:0] OFF_RX_FIFO_BASE = 8'h70;
    localparam logic [ADDR_W-1:0] REG_STEP = 8'h04;
    // Status bit positions
    localparam int RX_RDY_BIT = 0;
    localparam int TX_RDY_BIT = 1;
    // Enable register field positions
    localparam int EN_EP0_TX_BIT = 7;
    localparam int EN_RX_LSB = 8;
    localparam int EN_TX_LSB = 16;
    // Pending register field positions
    localparam int PEND_EP0_TX_BIT = 0;
    localparam int PEND_TX_LSB = 0;
    localparam int PEND_RX_LSB = 8;
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
endpackage : uepr_pkg

module uepr_ep_cell
    import uepr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Configuration
    input wire logic tx_en,
    input wire logic rx_en,
    // Firmware strobes
    input wire logic tx_arm_wr,
    input wire logic rx_ack_wr,
    input wire logic tx_push,
    // Link events
    input wire logic tx_free,
    input wire logic rx_done,
    input wire logic [CNT_W-1:0] rx_count,
    // State
    output logic tx_ready_r,
    output logic rx_ready_r,
    output logic tx_pend_r,
    output logic [CNT_W-1:0] rx_count_r,
    output logic [CNT_W-1:0] tx_len_r,
    output logic irq_r
);
    logic [CNT_W-1:0] tx_cnt_r;
    logic tx_ready_nxt;
    logic rx_ready_nxt;
    logic tx_pend_nxt;
    logic irq_nxt;

    // Arm on write one, a new arm beats a free
    assign tx_ready_nxt = tx_arm_wr | (tx_ready_r & ~tx_free);
    // Receive done sets, wins over firmware clear
    assign rx_ready_nxt = rx_done | (rx_ready_r & ~rx_ack_wr);
    assign tx_pend_nxt = tx_free | (tx_pend_r & ~tx_arm_wr);
    // Transmit interrupt gated by enable
    // Built from next state so an arm or a clear drops it at once
    assign irq_nxt = (tx_pend_nxt & tx_en) | (rx_ready_nxt & rx_en);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_ready_r <= 1'b0;
            rx_ready_r <= 1'b0;
            tx_pend_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            tx_ready_r <= tx_ready_nxt;
            rx_ready_r <= rx_ready_nxt;
            tx_pend_r <= tx_pend_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Loaded byte count becomes packet length
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_cnt_r <= CNT_ZERO;
            tx_len_r <= CNT_ZERO;
        end else if (tx_arm_wr) begin
            tx_cnt_r <= CNT_ZERO;
            tx_len_r <= tx_cnt_r;
        end else if (tx_push) begin
            tx_cnt_r <= tx_cnt_r + CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_count_r <= CNT_ZERO;
        end else if (rx_done) begin
            rx_count_r <= rx_count;
        end
    end
endmodule : uepr_ep_cell

// File: uepr_link_model.sv
// Behavioural link engine on the USB host side of the block
`timescale 1ns/1ps
module uepr_link_model
    import uepr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // From the block
    input wire logic [NUM_EP-1:0] ep_tx_armed,
    input wire logic rx_fifo_pop,
    // To the block
    output logic ctrl_read_data_stage,
    output logic [NUM_EP-1:0] ep_tx_ack,
    output logic [NUM_EP-1:1] ep_rx_done,
    output logic [NUM_EP*CNT_W-1:CNT_W] ep_rx_count,
    output logic [NUM_EP*BYTE_W-1:BYTE_W] rx_fifo_head
);
    logic [BYTE_W-1:0] pops_r;
    initial begin
        ctrl_read_data_stage = 1'b0;
        ep_tx_ack = '0;
        ep_rx_done = '0;
        ep_rx_count = '0;
    end
    // Head moves on each pop so a stale read shows
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pops_r <= 8'h00;
        end else if (rx_fifo_pop) begin
            pops_r <= pops_r + 8'h01;
        end
    end
    for (genvar n = 1; n < NUM_EP; n++) begin : g_head
        assign rx_fifo_head[n*BYTE_W+:BYTE_W] = pops_r + 8'(n * 16);
    end
    task data_stage();
        @(posedge clk_sys);
        ctrl_read_data_stage <= 1'b1;
        @(posedge clk_sys);
        ctrl_read_data_stage <= 1'b0;
    endtask : data_stage
    task ack(input int n);
        @(posedge clk_sys);
        if (ep_tx_armed[n] === 1'b1) begin
            ep_tx_ack[n] <= 1'b1;
            @(posedge clk_sys);
            ep_tx_ack[n] <= 1'b0;
        end
    endtask : ack
    task recv(input int n, input logic [CNT_W-1:0] cnt);
        @(posedge clk_sys);
        ep_rx_done[n] <= 1'b1;
        ep_rx_count[n*CNT_W+:CNT_W] <= cnt;
        @(posedge clk_sys);
        ep_rx_done[n] <= 1'b0;
        ep_rx_count[n*CNT_W+:CNT_W] <= ~cnt;
    endtask : recv
endmodule : uepr_link_model

// File: uepr_top.sv
// Endpoint packet-ready status, interrupt and APB register block
`timescale 1ns/1ps

module uepr_top
    import uepr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link engine events
    input wire logic ctrl_read_data_stage,
    input wire logic [NUM_EP-1:0] ep_tx_ack,
    input wire logic [NUM_EP-1:1] ep_rx_done,
    input wire logic [NUM_EP*CNT_W-1:CNT_W] ep_rx_count,
    input wire logic [NUM_EP*BYTE_W-1:BYTE_W] rx_fifo_head,
    // Link engine FIFO strobes
    output logic tx_fifo_push,
    output logic rx_fifo_pop,
    output logic [EP_SEL_W-1:0] fifo_ep_sel,
    output logic [BYTE_W-1:0] tx_fifo_byte,
    // Armed packets
    output logic [NUM_EP-1:0] ep_tx_armed,
    output logic [NUM_EP*CNT_W-1:0] ep_tx_len,
    // Interrupt
    output logic irq
);
    logic pready_r;
    logic pslverr_r;
    logic [DATA_W-1:0] prdata_r;
    logic tx_push_r;
    logic rx_pop_r;
    logic [EP_SEL_W-1:0] sel_r;
    logic [BYTE_W-1:0] tx_byte_r;
    logic irq_r;
    logic en_ctrl_tx_r;
    logic [NUM_EP-1:1] en_tx_r;
    logic [NUM_EP-1:1] en_rx_r;
    logic [NUM_EP-1:1] dir_tx_r;
    logic [NUM_EP-1:1] dir_tx_q_r;

    // Bus phases: one wait state on every access
    wire access = psel & penable;
    wire first_beat = access & ~pready_r;
    wire done = access & pready_r;
    wire wr_go = done & pwrite;
    wire rd_go = done & ~pwrite;

    wire hit_ctrl = paddr == OFF_CTRL_EP_STATUS;
    wire hit_en = paddr == OFF_INT_ENABLE_FIRST;
    wire hit_pend = paddr == OFF_INT_PENDING;
    wire hit_dir = paddr == OFF_EP_DIRECTION;

    // Per-endpoint decode and state
    logic [NUM_EP-1:0] tx_arm_wr;
    logic [NUM_EP-1:0] rx_ack_wr;
    logic [NUM_EP-1:0] tx_free;
    logic [NUM_EP-1:0] tx_ready;
    logic [NUM_EP-1:0] rx_ready;
    logic [NUM_EP-1:0] tx_pend;
    logic [NUM_EP-1:0] cell_irq;
    logic [NUM_EP-1:0] hit_txf;
    logic [NUM_EP-1:0] hit_rxf;
    logic [NUM_EP-1:0] hit_ep;
    logic [CNT_W-1:0] rx_cnt [NUM_EP];
    logic [CNT_W-1:0] tx_len [NUM_EP];
    logic [DATA_W-1:0] rd_chain [NUM_EP];
    logic [NUM_EP-1:0] hit_chain;

    // Pending view: transmit frees and receive readies
    wire [DATA_W-1:0] pend_word = DATA_W'(tx_pend) << PEND_TX_LSB
        | DATA_W'(rx_ready) << PEND_RX_LSB;
    // Enable view: endpoint n of 1 to 5 sits at its field base plus n, control transmit at bit 7
    wire [DATA_W-1:0] en_word = DATA_W'(en_ctrl_tx_r) << EN_EP0_TX_BIT
        | DATA_W'({en_rx_r, 1'b0}) << EN_RX_LSB
        | DATA_W'({en_tx_r, 1'b0}) << EN_TX_LSB;
    wire [DATA_W-1:0] ctrl_word = DATA_W'(tx_ready[0]) << TX_RDY_BIT;
    wire [DATA_W-1:0] dir_word = DATA_W'({dir_tx_r, 1'b0});

    // Control endpoint: only the transmit side lives here
    assign hit_txf[0] = paddr == OFF_TX_FIFO_BASE;
    assign hit_rxf[0] = 1'b0;
    assign hit_ep[0] = hit_ctrl;
    // Only a one in the bit arms
    assign tx_arm_wr[0] = wr_go & hit_ctrl & pwdata[TX_RDY_BIT];
    assign rx_ack_wr[0] = 1'b0;
    // Data stage of a control read frees the FIFO
    // Later packets freed by host ACK or by another data stage
    assign tx_free[0] = ctrl_read_data_stage | (ep_tx_ack[0] & tx_ready[0]);
    assign rd_chain[0] = (hit_ctrl ? ctrl_word : WORD_ZERO)
        | (hit_en ? en_word : WORD_ZERO)
        | (hit_pend ? pend_word : WORD_ZERO)
        | (hit_dir ? dir_word : WORD_ZERO);
    assign hit_chain[0] = hit_ctrl | hit_en | hit_pend | hit_dir | hit_txf[0];

    // Control cell, receive side tied off
    uepr_ep_cell u_cell_ctrl (
        .clk_sys(clk_sys),
        .rstn(rstn),
        // Control transmit interrupt gated by its enable
        .tx_en(en_ctrl_tx_r),
        .rx_en(1'b0),
        .tx_arm_wr(tx_arm_wr[0]),
        .rx_ack_wr(rx_ack_wr[0]),
        .tx_push(tx_push_r && sel_r == '0),
        .tx_free(tx_free[0]),
        .rx_done(1'b0),
        .rx_count(CNT_ZERO),
        .tx_ready_r(tx_ready[0]),
        .rx_ready_r(rx_ready[0]),
        .tx_pend_r(tx_pend[0]),
        .rx_count_r(rx_cnt[0]),
        .tx_len_r(tx_len[0]),
        .irq_r(cell_irq[0])
    );

    // Endpoints 1 to 5: decode, read mux and a cell each
    genvar n;
    generate
        for (n = 1; n < NUM_EP; n++) begin : g_ep
            // Word decode of this endpoint's registers
            localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(OFF_EP_STATUS_BASE + REG_STEP * (n - 1));
            localparam logic [ADDR_W-1:0] A_RXC = ADDR_W'(OFF_RX_COUNT_BASE + REG_STEP * (n - 1));
            localparam logic [ADDR_W-1:0] A_TXF = ADDR_W'(OFF_TX_FIFO_BASE + REG_STEP * n);
            localparam logic [ADDR_W-1:0] A_RXF = ADDR_W'(OFF_RX_FIFO_BASE + REG_STEP * (n - 1));
            wire hit_rxc = paddr == A_RXC;
            wire [DATA_W-1:0] stat_word = DATA_W'(tx_ready[n]) << TX_RDY_BIT
                | DATA_W'(rx_ready[n]) << RX_RDY_BIT;
            wire [DATA_W-1:0] head_word = DATA_W'(rx_fifo_head[n*BYTE_W +: BYTE_W]);
            assign hit_ep[n] = paddr == A_STAT;
            assign hit_txf[n] = paddr == A_TXF;
            assign hit_rxf[n] = paddr == A_RXF;
            // Zero bits leave the ready flags alone
            assign tx_arm_wr[n] = wr_go & hit_ep[n] & pwdata[TX_RDY_BIT] & dir_tx_r[n];
            // Write one releases the received packet
            assign rx_ack_wr[n] = wr_go & hit_ep[n] & pwdata[RX_RDY_BIT];
            // Writable on entering transmit or after ACK
            assign tx_free[n] = dir_tx_r[n] & ((dir_tx_r[n] & ~dir_tx_q_r[n])
                | (ep_tx_ack[n] & tx_ready[n]));
            assign rd_chain[n] = rd_chain[n-1]
                | (hit_ep[n] ? stat_word : WORD_ZERO)
                | (hit_rxc ? DATA_W'(rx_cnt[n]) : WORD_ZERO)
                | (hit_rxf[n] ? head_word : WORD_ZERO);
            assign hit_chain[n] = hit_chain[n-1] | hit_ep[n] | hit_rxc | hit_txf[n] | hit_rxf[n];

            uepr_ep_cell u_cell (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .tx_en(en_tx_r[n] & dir_tx_r[n]),
                .rx_en(en_rx_r[n]),
                .tx_arm_wr(tx_arm_wr[n]),
                .rx_ack_wr(rx_ack_wr[n]),
                .tx_push(tx_push_r && sel_r == EP_SEL_W'(n)),
                .tx_free(tx_free[n]),
                // Clean end-of-packet from a receive endpoint
                .rx_done(ep_rx_done[n] & ~dir_tx_r[n]),
                .rx_count(ep_rx_count[n*CNT_W +: CNT_W]),
                .tx_ready_r(tx_ready[n]),
                .rx_ready_r(rx_ready[n]),
                .tx_pend_r(tx_pend[n]),
                .rx_count_r(rx_cnt[n]),
                .tx_len_r(tx_len[n]),
                .irq_r(cell_irq[n])
            );
        end
        for (n = 0; n < NUM_EP; n++) begin : g_len
            assign ep_tx_len[n*CNT_W +: CNT_W] = tx_len[n];
        end
    endgenerate

    // Unmapped offsets answer with pslverr and read zero
    wire hit_any = hit_chain[NUM_EP-1];
    wire any_txf = |hit_txf;
    wire any_rxf = |hit_rxf;

    // FIFO endpoint index from the one-hot hits
    logic [EP_SEL_W-1:0] fifo_idx;
    always_comb begin
        fifo_idx = '0;
        for (int i = 0; i < NUM_EP; i++) begin
            if (hit_txf[i] || hit_rxf[i]) begin
                fifo_idx = EP_SEL_W'(i);
            end
        end
    end

    // Bus handshake: fixed single wait state
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= first_beat;
            pslverr_r <= first_beat & ~hit_any;
        end
    end

    // Read data taken at the first access edge and held,
    // so it still stands when pready is sampled
    wire [DATA_W-1:0] rd_word = pwrite ? WORD_ZERO : rd_chain[NUM_EP-1];
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata_r <= WORD_ZERO;
        end else if (first_beat) begin
            prdata_r <= rd_word;
        end
    end

    // Interrupt enables
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            en_ctrl_tx_r <= 1'b0;
            en_tx_r <= '0;
            en_rx_r <= '0;
        end else if (wr_go && hit_en) begin
            en_ctrl_tx_r <= pwdata[EN_EP0_TX_BIT];
            en_rx_r <= pwdata[EN_RX_LSB+1 +: NUM_EP-1];
            en_tx_r <= pwdata[EN_TX_LSB+1 +: NUM_EP-1];
        end
    end

    // Directions; turning to transmit frees the FIFO a cycle later
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dir_tx_r <= '0;
        end else if (wr_go && hit_dir) begin
            dir_tx_r <= pwdata[1 +: NUM_EP-1];
        end
    end

    // FIFO strobes toward the link engine
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_push_r <= 1'b0;
            rx_pop_r <= 1'b0;
            sel_r <= '0;
            tx_byte_r <= '0;
        end else begin
            tx_push_r <= wr_go & any_txf;
            rx_pop_r <= rd_go & any_rxf;
            if (done && (any_txf || any_rxf)) begin
                sel_r <= fifo_idx;
            end
            if (wr_go && any_txf) begin
                tx_byte_r <= pwdata[BYTE_W-1:0];
            end
        end
    end

    // Interrupt out; costs a cycle but leaves no gate on the pin
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |cell_irq;
        end
    end

    // Direction history for the entering-transmit edge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dir_tx_q_r <= '0;
        end else begin
            dir_tx_q_r <= dir_tx_r;
        end
    end

    // Every output straight from its flop
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign tx_fifo_push = tx_push_r;
    assign rx_fifo_pop = rx_pop_r;
    assign fifo_ep_sel = sel_r;
    assign tx_fifo_byte = tx_byte_r;
    assign ep_tx_armed = tx_ready;
    assign irq = irq_r;
endmodule : uepr_top

// File: uepr_top_tb_top.sv
// Self-checking bench for the endpoint packet-ready block
`timescale 1ns/1ps
module uepr_top_tb_top
    import uepr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic ctrl_read_data_stage;
    logic [NUM_EP-1:0] ep_tx_ack;
    logic [NUM_EP-1:1] ep_rx_done;
    logic [NUM_EP*CNT_W-1:CNT_W] ep_rx_count;
    logic [NUM_EP*BYTE_W-1:BYTE_W] rx_fifo_head;
    logic tx_fifo_push;
    logic rx_fifo_pop;
    logic [EP_SEL_W-1:0] fifo_ep_sel;
    logic [BYTE_W-1:0] tx_fifo_byte;
    logic [NUM_EP-1:0] ep_tx_armed;
    logic [NUM_EP*CNT_W-1:0] ep_tx_len;
    logic irq;
    logic [DATA_W-1:0] rd;
    logic err;
    logic [ADDR_W-1:0] ofs;
    int num_errors = 0;
    int comparisons = 0;
    int pops = 0;
    always #10 clk_sys = ~clk_sys;
    uepr_top uepr_top_i (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ctrl_read_data_stage(ctrl_read_data_stage),
        .ep_tx_ack(ep_tx_ack),
        .ep_rx_done(ep_rx_done),
        .ep_rx_count(ep_rx_count),
        .rx_fifo_head(rx_fifo_head),
        .tx_fifo_push(tx_fifo_push),
        .rx_fifo_pop(rx_fifo_pop),
        .fifo_ep_sel(fifo_ep_sel),
        .tx_fifo_byte(tx_fifo_byte),
        .ep_tx_armed(ep_tx_armed),
        .ep_tx_len(ep_tx_len),
        .irq(irq)
    );
    uepr_link_model uepr_link_model_i (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ep_tx_armed(ep_tx_armed),
        .rx_fifo_pop(rx_fifo_pop),
        .ctrl_read_data_stage(ctrl_read_data_stage),
        .ep_tx_ack(ep_tx_ack),
        .ep_rx_done(ep_rx_done),
        .ep_rx_count(ep_rx_count),
        .rx_fifo_head(rx_fifo_head)
    );
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic idle(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : idle
    task automatic end_of_test();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #100us;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        apb(1, OFF_CTRL_EP_STATUS, WORD_ZERO);
        chk(32'(ep_tx_armed), 32'h0);
        for (int i = 0; i < 3; i++) begin
            apb(1, OFF_TX_FIFO_BASE, 32'(8'ha0 + i));
        end
        apb(1, OFF_CTRL_EP_STATUS, 32'h2);
        chk(32'(ep_tx_armed), 32'h1);
        chk(32'(ep_tx_len[CNT_W-1:0]), 32'h3);
        uepr_link_model_i.data_stage();
        idle(3);
        chk(32'({ep_tx_armed[0], irq}), 32'h0);
        apb(1, OFF_INT_ENABLE_FIRST, 32'h80);
        idle(2);
        chk(32'(irq), 32'h1);
        // Null packet: arm with nothing loaded
        apb(1, OFF_CTRL_EP_STATUS, 32'h2);
        idle(1);
        chk(32'({ep_tx_armed[0], irq}), 32'h2);
        chk(32'(ep_tx_len[CNT_W-1:0]), 32'h0);
        idle(20);
        chk(32'({ep_tx_armed[0], irq}), 32'h2);
        uepr_link_model_i.ack(0);
        idle(3);
        chk(32'({ep_tx_armed[0], irq}), 32'h1);
        apb(1, OFF_CTRL_EP_STATUS, 32'h2);
        // Odd receive endpoints enabled only
        apb(1, OFF_INT_ENABLE_FIRST, 32'h2a00);
        for (int n = 1; n < NUM_EP; n++) begin
            ofs = 8'(n - 1) * REG_STEP;
            uepr_link_model_i.recv(n, CNT_W'(n + 1));
            idle(2);
            chk(32'(irq), 32'(n % 2));
            apb(0, OFF_EP_STATUS_BASE + ofs, WORD_ZERO);
            chk(rd, 32'h1);
            apb(0, OFF_RX_COUNT_BASE + ofs, WORD_ZERO);
            chk(rd, 32'(n + 1));
            for (int k = 0; k <= n; k++) begin
                apb(0, OFF_RX_FIFO_BASE + ofs, WORD_ZERO);
                chk(rd, 32'(8'(pops + n * 16)));
                pops++;
            end
            apb(1, OFF_EP_STATUS_BASE + ofs, WORD_ZERO);
            apb(0, OFF_EP_STATUS_BASE + ofs, WORD_ZERO);
            chk(rd, 32'h1);
            apb(1, OFF_EP_STATUS_BASE + ofs, 32'h1);
            idle(1);
            chk(32'(irq), 32'h0);
        end
        // All of 1..5 turn to transmit, only endpoint 1 enabled
        apb(1, OFF_EP_DIRECTION, 32'h3e);
        apb(1, OFF_INT_ENABLE_FIRST, 32'h20000);
        idle(2);
        chk(32'(irq), 32'h1);
        apb(1, OFF_TX_FIFO_BASE + 8'h04, 32'h55);
        apb(1, OFF_TX_FIFO_BASE + 8'h04, 32'h66);
        chk(32'({fifo_ep_sel, tx_fifo_byte}), 32'h166);
        apb(1, OFF_EP_STATUS_BASE, 32'h2);
        idle(1);
        chk(32'({ep_tx_armed, irq}), 32'h6);
        chk(32'(ep_tx_len[CNT_W+:CNT_W]), 32'h2);
        uepr_link_model_i.ack(1);
        idle(3);
        chk(32'({ep_tx_armed[1], irq}), 32'h1);
        apb(0, OFF_INT_PENDING, WORD_ZERO);
        chk(rd, 32'h3e);
        apb(0, OFF_INT_ENABLE_FIRST, WORD_ZERO);
        chk(rd, 32'h20000);
        apb(0, 8'hfc, WORD_ZERO);
        chk({rd[30:0], err}, 32'h1);
        end_of_test();
    end
endmodule : uepr_top_tb_top
